/* File: sim/sdram_cmd_checker.sv */
// Checker of the SDRAM command pins against the decoder outputs.
`include "sdram_cmd_map.svh"
`default_nettype none
module sdram_cmd_checker (
  // Clock and reset.
  input wire logic                 i_clk,
  input wire logic                 i_reset,
  // Command pins.
  input wire logic                 cs_n,
  input wire logic                 ras_n,
  input wire logic                 cas_n,
  input wire logic                 we_n,
  input wire logic                 cke,
  input wire logic                 dqm,
  input wire logic                 bank_select_low,
  input wire logic                 bank_select_high,
  input wire logic [11:0]          addr,
  // Decoder outputs.
  input wire logic                 o_cmd_valid,
  input wire sdram_cmd_pkg::cmd_t  o_cmd,
  input wire logic [3:0]           o_bank_active,
  input wire sdram_cmd_pkg::mode_t o_mode,
  input wire logic                 o_clk_run,
  input wire logic                 o_data_enable,
  input wire logic                 o_illegal
);
  timeunit 1ns;
  timeprecision 1ps;
  // =========================================================
  // Helpers
  // Enable level one edge back; reset matches the decoder's high start.
  logic cke_q;
  always_ff @(posedge i_clk) cke_q <= i_reset ? 1'b1 : cke;
  wire       run  = o_mode == sdram_cmd_pkg::MODE_RUN;
  wire       susp = o_mode == sdram_cmd_pkg::MODE_SUSP;
  wire       pd   = o_mode == sdram_cmd_pkg::MODE_PD;
  // Both enable samples high in run mode: an ordinary command edge.
  wire       go   = run && cke && cke_q;
  wire [3:0] pat  = {cs_n, ras_n, cas_n, we_n};
  wire [1:0] bk   = {bank_select_high, bank_select_low};
  wire       idle = o_bank_active == 4'h0;
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_reset);
  // =========================================================
  // Assertions
  nop_keeps_a: assert property (
    go && pat == `PAT_NOP |=> !o_illegal && $stable(o_bank_active))
    else $error("no-operation disturbed bank state");
  desel_nop_a: assert property (
    go && cs_n |=> !o_illegal && $stable(o_bank_active))
    else $error("deselect disturbed bank state");
  susp_entry_a: assert property (
    run && !idle && cke_q && !cke |=> susp && !o_clk_run)
    else $error("suspend not entered one clock after enable fell");
  susp_hold_a: assert property (
    susp && !cke |=> !o_cmd_valid && $stable(o_bank_active))
    else $error("command taken while suspended");
  susp_exit_a: assert property (
    susp && cke |=> run && o_clk_run && o_cmd == sdram_cmd_pkg::CMD_SUSP_OUT)
    else $error("suspend not left one clock after enable rose");
  pd_entry_a: assert property (
    run && idle && cke_q && !cke && (cs_n || (ras_n && cas_n)) |=> pd)
    else $error("power-down not entered");
  pd_exit_a: assert property (
    pd && cke && (cs_n || (ras_n && cas_n)) |=> run)
    else $error("power-down not left");
  act_open_a: assert property (
    go && pat == `PAT_ACT && !o_bank_active[bk] |=> o_bank_active[$past(bk)])
    else $error("activate did not open its bank");
  rw_closed_a: assert property (
    go && !cs_n && ras_n && !cas_n && !o_bank_active[bk] |=> o_illegal)
    else $error("access to closed bank not flagged");
  pre_all_a: assert property (
    go && pat == `PAT_PRE && addr[`FLAG_BIT] |=> idle)
    else $error("precharge all left a bank open");
  mask_off_a: assert property (
    go && !idle && dqm |=> !o_data_enable)
    else $error("byte mask high left data enabled");
  // Main scenarios reached.
  cover property (susp);
  cover property (pd);
  cover property (o_mode == sdram_cmd_pkg::MODE_SREF);
endmodule // sdram_cmd_checker
`default_nettype wire

/* File: sim/tb.sv */
// Testbench joining the SDRAM controller and decoder across the pins.
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  // =========================================================
  // Stimulus and observed signals
  logic        i_clk   = 1'b0; // 200 MHz clock.
  logic        i_reset = 1'b1; // Synchronous reset, held 6 cycles.
  logic        i_req   = 1'b0;
  sdram_cmd_pkg::cmd_t i_cmd = sdram_cmd_pkg::CMD_NOP; // Requested command.
  logic [1:0]  i_bank  = 2'h0;
  logic [11:0] i_addr  = 12'h000;
  logic        i_mask  = 1'b1;
  logic        i_cke   = 1'b1;
  logic        o_ready, o_cmd_valid, o_clk_run, o_burst_busy;
  logic        o_data_enable, o_illegal;
  sdram_cmd_pkg::cmd_t  o_cmd;  // Last decoded command.
  sdram_cmd_pkg::mode_t o_mode; // Decoder clock-enable mode.
  logic [1:0]  o_cmd_bank;
  logic [3:0]  o_bank_active;
  int          fail_count  = 0;
  int          comparisons = 0;
  always #2.5 i_clk = ~i_clk;
  // =========================================================
  // The two ends and the checker on the shared pins
  sdram_cmd_if u_sdram_cmd_if ();
  sdram_cmd_ctrl u_sdram_cmd_ctrl (.i_clk(i_clk), .i_reset(i_reset), .i_req(i_req),
    .i_cmd(i_cmd), .i_bank(i_bank), .i_addr(i_addr), .i_mask(i_mask), .i_cke(i_cke),
    .o_ready(o_ready), .pins(u_sdram_cmd_if));
  sdram_cmd_decode u_sdram_cmd_decode (.i_clk(i_clk), .i_reset(i_reset),
    .pins(u_sdram_cmd_if), .o_cmd_valid(o_cmd_valid), .o_cmd(o_cmd),
    .o_cmd_bank(o_cmd_bank), .o_bank_active(o_bank_active), .o_mode(o_mode),
    .o_clk_run(o_clk_run), .o_burst_busy(o_burst_busy),
    .o_data_enable(o_data_enable), .o_illegal(o_illegal));
  sdram_cmd_checker u_sdram_cmd_checker (.i_clk(i_clk), .i_reset(i_reset),
    .cs_n(u_sdram_cmd_if.cs_n), .ras_n(u_sdram_cmd_if.ras_n),
    .cas_n(u_sdram_cmd_if.cas_n), .we_n(u_sdram_cmd_if.we_n),
    .cke(u_sdram_cmd_if.cke), .dqm(u_sdram_cmd_if.dqm),
    .bank_select_low(u_sdram_cmd_if.bank_select_low),
    .bank_select_high(u_sdram_cmd_if.bank_select_high), .addr(u_sdram_cmd_if.addr),
    .o_cmd_valid(o_cmd_valid), .o_cmd(o_cmd), .o_bank_active(o_bank_active),
    .o_mode(o_mode), .o_clk_run(o_clk_run), .o_data_enable(o_data_enable),
    .o_illegal(o_illegal));
  // =========================================================
  // Shared tasks
  // Compare with case equality so an unknown never matches.
  task automatic check(input string name, input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      fail_count++;
      $display("MISMATCH %s expected %0h seen %0h", name, exp, got);
    end
  endtask
  // One request; the decoder answers one edge after the controller takes it.
  task automatic send(input sdram_cmd_pkg::cmd_t c, input logic [1:0] b,
                      input logic [11:0] a, input logic k);
    @(negedge i_clk);
    i_req  = 1'b1;
    i_cmd  = c;
    i_bank = b;
    i_addr = a;
    i_cke  = k;
    @(negedge i_clk);
    i_req = 1'b0;
    @(negedge i_clk);
  endtask
  task automatic end_sim();
    $display("comparisons %0d mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  // =========================================================
  // Scenarios
  // Values both ends must show straight after reset.
  task automatic t_reset();
    check("mode", o_mode, sdram_cmd_pkg::MODE_RUN);
    check("clk_run", o_clk_run, 1'b1);
    check("banks", o_bank_active, 4'h0);
    check("ready", o_ready, 1'b1);
    $display("test reset done");
  endtask
  // Open a bank, then idle cycles, a closed-bank write and the byte mask.
  task automatic t_access();
    send(sdram_cmd_pkg::CMD_ACT, 2'h1, 12'h000, 1'b1);
    check("act valid", o_cmd_valid, 1'b1);
    check("act cmd", o_cmd, sdram_cmd_pkg::CMD_ACT);
    check("act bank", o_cmd_bank, 2'h1);
    check("act banks", o_bank_active, 4'h2);
    // A second activate to an open bank is flagged and changes nothing.
    send(sdram_cmd_pkg::CMD_ACT, 2'h1, 12'h000, 1'b1);
    check("reopen illegal", o_illegal, 1'b1);
    check("reopen banks", o_bank_active, 4'h2);
    send(sdram_cmd_pkg::CMD_NOP, 2'h1, 12'h000, 1'b1);
    check("nop banks", o_bank_active, 4'h2);
    check("nop illegal", o_illegal, 1'b0);
    send(sdram_cmd_pkg::CMD_DESEL, 2'h3, 12'hFFF, 1'b1);
    check("desel banks", o_bank_active, 4'h2);
    check("desel illegal", o_illegal, 1'b0);
    send(sdram_cmd_pkg::CMD_WRITE, 2'h2, 12'h000, 1'b1);
    check("write cmd", o_cmd, sdram_cmd_pkg::CMD_WRITE);
    check("closed write", o_illegal, 1'b1);
    i_mask = 1'b0;
    send(sdram_cmd_pkg::CMD_NOP, 2'h1, 12'h000, 1'b1);
    check("unmasked", o_data_enable, 1'b1);
    i_mask = 1'b1;
    send(sdram_cmd_pkg::CMD_NOP, 2'h1, 12'h000, 1'b1);
    check("masked", o_data_enable, 1'b0);
    $display("test access done");
  endtask
  // Drop the enable in mid-burst: suspend, not power-down, then resume.
  task automatic t_suspend();
    send(sdram_cmd_pkg::CMD_READ, 2'h1, 12'h000, 1'b1);
    check("read cmd", o_cmd, sdram_cmd_pkg::CMD_READ);
    check("burst", o_burst_busy, 1'b1);
    send(sdram_cmd_pkg::CMD_NOP, 2'h1, 12'h000, 1'b0);
    check("susp mode", o_mode, sdram_cmd_pkg::MODE_SUSP);
    check("susp clk", o_clk_run, 1'b0);
    send(sdram_cmd_pkg::CMD_ACT, 2'h2, 12'h000, 1'b0);
    check("susp valid", o_cmd_valid, 1'b0);
    check("susp banks", o_bank_active, 4'h2);
    send(sdram_cmd_pkg::CMD_NOP, 2'h1, 12'h000, 1'b1);
    check("resume mode", o_mode, sdram_cmd_pkg::MODE_RUN);
    check("resume cmd", o_cmd, sdram_cmd_pkg::CMD_SUSP_OUT);
    $display("test suspend done");
  endtask
  // Single-bank and all-bank precharge chosen by the flag bit.
  task automatic t_precharge();
    send(sdram_cmd_pkg::CMD_PRE, 2'h1, 12'h000, 1'b1);
    check("pre cmd", o_cmd, sdram_cmd_pkg::CMD_PRE);
    check("pre bank", o_cmd_bank, 2'h1);
    check("pre banks", o_bank_active, 4'h0);
    send(sdram_cmd_pkg::CMD_ACT, 2'h0, 12'h000, 1'b1);
    send(sdram_cmd_pkg::CMD_ACT, 2'h3, 12'h000, 1'b1);
    check("two banks", o_bank_active, 4'h9);
    // Mode register set with banks open is refused.
    send(sdram_cmd_pkg::CMD_MRS, 2'h0, 12'h000, 1'b1);
    check("mrs open", o_illegal, 1'b1);
    // The controller raises the flag bit itself for the all-bank form.
    send(sdram_cmd_pkg::CMD_PREALL, 2'h0, 12'h000, 1'b1);
    check("preall cmd", o_cmd, sdram_cmd_pkg::CMD_PREALL);
    check("preall banks", o_bank_active, 4'h0);
    $display("test precharge done");
  endtask
  // Idle-only commands, burst stop refusal, power-down and self refresh.
  task automatic t_idle();
    send(sdram_cmd_pkg::CMD_MRS, 2'h0, 12'h000, 1'b1);
    check("mrs cmd", o_cmd, sdram_cmd_pkg::CMD_MRS);
    check("mrs idle", o_illegal, 1'b0);
    send(sdram_cmd_pkg::CMD_AREF, 2'h0, 12'h000, 1'b1);
    check("aref cmd", o_cmd, sdram_cmd_pkg::CMD_AREF);
    check("aref idle", o_illegal, 1'b0);
    send(sdram_cmd_pkg::CMD_BSTOP, 2'h0, 12'h000, 1'b1);
    check("bstop", o_illegal, 1'b1);
    send(sdram_cmd_pkg::CMD_NOP, 2'h0, 12'h000, 1'b0);
    check("pd mode", o_mode, sdram_cmd_pkg::MODE_PD);
    check("pd cmd", o_cmd, sdram_cmd_pkg::CMD_PD_IN);
    send(sdram_cmd_pkg::CMD_DESEL, 2'h0, 12'h000, 1'b1);
    check("pd exit mode", o_mode, sdram_cmd_pkg::MODE_RUN);
    check("pd exit cmd", o_cmd, sdram_cmd_pkg::CMD_PD_OUT);
    send(sdram_cmd_pkg::CMD_SREF_IN, 2'h0, 12'h000, 1'b0);
    check("sref mode", o_mode, sdram_cmd_pkg::MODE_SREF);
    send(sdram_cmd_pkg::CMD_NOP, 2'h0, 12'h000, 1'b1);
    check("sref exit", o_mode, sdram_cmd_pkg::MODE_RUN);
    $display("test idle modes done");
  endtask
  // =========================================================
  // Main sequence
  initial begin
    repeat (6) @(negedge i_clk);
    i_reset = 1'b0;
    t_reset();
    t_access();
    t_suspend();
    t_precharge();
    t_idle();
    end_sim();
  end
endmodule // tb
`default_nettype wire

/* File: verilog/sdram_cmd_ctrl.sv */
// Controller end: drives command pins from a simple user request port.
`include "sdram_cmd_map.svh"
`default_nettype none
module sdram_cmd_ctrl (
  // Clock and reset.
  input  wire logic                 i_clk,
  input  wire logic                 i_reset,
  // User request.
  input  wire logic                 i_req,
  input  wire sdram_cmd_pkg::cmd_t  i_cmd,
  input  wire logic [1:0]           i_bank,
  input  wire logic [11:0]          i_addr,
  input  wire logic                 i_mask,
  input  wire logic                 i_cke,
  output logic                      o_ready,
  // Command pins.
  sdram_cmd_if.ctrl                 pins
);

  // ==========================================================================
  // Registered pin drivers; idle shows a NOP with enable from i_cke, high out of reset.
  logic [3:0]  pat_r, pat_nxt;
  logic        cke_r, cke_nxt;
  logic        dqm_r, dqm_nxt;
  logic [1:0]  bank_r, bank_nxt;
  logic [11:0] addr_r, addr_nxt;

  // Pattern chosen for the request.
  logic [3:0] req_pat;
  logic       req_ok;

  // Burst stop and power-down are the user's duty; only pattern mapping here.
  always_comb begin
    req_pat = `PAT_NOP;
    req_ok  = 1'b1;
    unique case (i_cmd)
      sdram_cmd_pkg::CMD_ACT:    req_pat = `PAT_ACT;
      sdram_cmd_pkg::CMD_PRE,
      sdram_cmd_pkg::CMD_PREALL: req_pat = `PAT_PRE;
      sdram_cmd_pkg::CMD_READ:   req_pat = `PAT_READ;
      sdram_cmd_pkg::CMD_WRITE:  req_pat = `PAT_WRITE;
      sdram_cmd_pkg::CMD_MRS:    req_pat = `PAT_MRS;
      sdram_cmd_pkg::CMD_BSTOP:  req_pat = `PAT_BSTOP;
      sdram_cmd_pkg::CMD_AREF,
      sdram_cmd_pkg::CMD_SREF_IN: req_pat = `PAT_REF;
      sdram_cmd_pkg::CMD_DESEL:  req_pat = `PAT_DESEL;
      default:                   req_pat = `PAT_NOP;
    endcase
  end

  // ==========================================================================
  // Next pin values. Enable follows i_cke, except that a self-refresh request drives it low.
  always_comb begin
    pat_nxt  = `PAT_NOP;
    cke_nxt  = i_cke;
    dqm_nxt  = i_mask;
    bank_nxt = bank_r;
    addr_nxt = addr_r;
    if (i_req && req_ok) begin
      pat_nxt  = req_pat;
      bank_nxt = i_bank;
      addr_nxt = i_addr;
      if (i_cmd == sdram_cmd_pkg::CMD_PREALL) addr_nxt[`FLAG_BIT] = 1'b1;
      if (i_cmd == sdram_cmd_pkg::CMD_PRE) addr_nxt[`FLAG_BIT] = 1'b0;
      if (i_cmd == sdram_cmd_pkg::CMD_SREF_IN) cke_nxt = 1'b0;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      pat_r  <= `PAT_NOP;
      cke_r  <= 1'b1;
      dqm_r  <= 1'b1;
      bank_r <= 2'h0;
      addr_r <= 12'h000;
    end else begin
      pat_r  <= pat_nxt;
      cke_r  <= cke_nxt;
      dqm_r  <= dqm_nxt;
      bank_r <= bank_nxt;
      addr_r <= addr_nxt;
    end
  end

  assign o_ready               = 1'b1;
  assign pins.cs_n             = pat_r[3];
  assign pins.ras_n            = pat_r[2];
  assign pins.cas_n            = pat_r[1];
  assign pins.we_n             = pat_r[0];
  assign pins.cke              = cke_r;
  assign pins.dqm              = dqm_r;
  assign pins.bank_select_low  = bank_r[0];
  assign pins.bank_select_high = bank_r[1];
  assign pins.addr             = addr_r;

endmodule // sdram_cmd_ctrl
`default_nettype wire

/* File: verilog/sdram_cmd_decode.sv */
// Device end: command decoder with clock-suspend and power-down handling.
`include "sdram_cmd_map.svh"
`default_nettype none
module sdram_cmd_decode (
  // Clock and reset.
  input  wire logic                  i_clk,
  input  wire logic                  i_reset,
  // Command pins.
  sdram_cmd_if.dev                   pins,
  // Decoded state towards the array.
  output logic                       o_cmd_valid,
  output sdram_cmd_pkg::cmd_t        o_cmd,
  output logic [1:0]                 o_cmd_bank,
  output logic [`NUM_BANKS-1:0]      o_bank_active,
  output sdram_cmd_pkg::mode_t       o_mode,
  output logic                       o_clk_run,
  output logic                       o_burst_busy,
  output logic                       o_data_enable,
  output logic                       o_illegal
);

  // ==========================================================================
  // State.
  logic                  cke_prev_r, cke_prev_nxt;     // Enable at the previous edge.
  sdram_cmd_pkg::mode_t  mode_r, mode_nxt;             // Clock-enable mode.
  logic                  run_r, run_nxt;               // Internal clock running.
  logic [`NUM_BANKS-1:0] act_r, act_nxt;               // Open banks.
  logic [7:0]            burst_r, burst_nxt;           // Remaining burst beats.
  logic                  full_page_r, full_page_nxt;   // Burst is full page.
  logic                  vld_r, vld_nxt;
  sdram_cmd_pkg::cmd_t   cmd_r, cmd_nxt;
  logic [1:0]            bank_r, bank_nxt;
  logic                  de_r, de_nxt;
  logic                  ill_r, ill_nxt;

  // Combinational views of the pins.
  logic [3:0] pat;
  logic [1:0] bank;
  logic       nop_like;

  assign pat      = {pins.cs_n, pins.ras_n, pins.cas_n, pins.we_n};
  assign bank     = {pins.bank_select_high, pins.bank_select_low};
  // Deselect or CS low with row and column strobes high both qualify.
  assign nop_like = pins.cs_n | (pins.ras_n & pins.cas_n);

  // ==========================================================================
  // Next-state logic. All pins are sampled only at the rising edge.
  always_comb begin
    cke_prev_nxt  = pins.cke;
    mode_nxt      = mode_r;
    run_nxt       = run_r;
    act_nxt       = act_r;
    burst_nxt     = burst_r;
    full_page_nxt = full_page_r;
    vld_nxt       = 1'b0;
    cmd_nxt       = cmd_r;
    bank_nxt      = bank;
    ill_nxt       = 1'b0;
    // Mask acts only while some bank is open.
    de_nxt        = (|act_r) & ~pins.dqm;
    // A running burst counts down only while the internal clock runs.
    if (run_r && burst_r != 8'h00 && !full_page_r) begin
      burst_nxt = burst_r - 8'h01;
    end
    unique case (mode_r)
      sdram_cmd_pkg::MODE_RUN: begin
        // Enable must have been high at the previous edge for normal commands.
        if (cke_prev_r && !pins.cke) begin
          vld_nxt = 1'b1;
          // Falling enable: suspend if any bank open or a burst runs.
          if ((|act_r) || burst_r != 8'h00) begin
            cmd_nxt  = sdram_cmd_pkg::CMD_SUSP_IN;
            mode_nxt = sdram_cmd_pkg::MODE_SUSP;
            // The freeze takes hold one edge after the low sample.
            run_nxt  = 1'b0;
          end else if (pat == `PAT_REF) begin
            cmd_nxt  = sdram_cmd_pkg::CMD_SREF_IN;
            mode_nxt = sdram_cmd_pkg::MODE_SREF;
            run_nxt  = 1'b0;
          end else if (nop_like) begin
            cmd_nxt  = sdram_cmd_pkg::CMD_PD_IN;
            mode_nxt = sdram_cmd_pkg::MODE_PD;
            run_nxt  = 1'b0;
          end else begin
            cmd_nxt = sdram_cmd_pkg::CMD_NOP;
            ill_nxt = 1'b1;
          end
        end else if (cke_prev_r) begin
          vld_nxt = 1'b1;
          if (pins.cs_n) begin
            cmd_nxt = sdram_cmd_pkg::CMD_DESEL;
          end else begin
            unique case (pat)
              `PAT_NOP: cmd_nxt = sdram_cmd_pkg::CMD_NOP;
              `PAT_ACT: begin
                cmd_nxt = sdram_cmd_pkg::CMD_ACT;
                if (act_r[bank]) ill_nxt = 1'b1;
                act_nxt[bank] = 1'b1;
              end
              `PAT_PRE: begin
                // Flag bit high closes every bank.
                if (pins.addr[`FLAG_BIT]) begin
                  cmd_nxt = sdram_cmd_pkg::CMD_PREALL;
                  act_nxt = '0;
                end else begin
                  cmd_nxt = sdram_cmd_pkg::CMD_PRE;
                  act_nxt[bank] = 1'b0;
                end
                burst_nxt = 8'h00;
                full_page_nxt = 1'b0;
              end
              `PAT_READ, `PAT_WRITE: begin
                cmd_nxt = pins.we_n ? sdram_cmd_pkg::CMD_READ
                                    : sdram_cmd_pkg::CMD_WRITE;
                if (act_r[bank]) begin
                  burst_nxt = `BURST_LEN;
                end else begin
                  ill_nxt = 1'b1;
                end
              end
              `PAT_BSTOP: begin
                cmd_nxt = sdram_cmd_pkg::CMD_BSTOP;
                // Only meaningful in full page; otherwise flagged.
                if (!full_page_r) ill_nxt = 1'b1;
                burst_nxt = 8'h00;
                full_page_nxt = 1'b0;
              end
              `PAT_REF: begin
                cmd_nxt = sdram_cmd_pkg::CMD_AREF;
                if (|act_r) ill_nxt = 1'b1;
              end
              `PAT_MRS: begin
                cmd_nxt = sdram_cmd_pkg::CMD_MRS;
                if (|act_r) ill_nxt = 1'b1;
              end
              default: cmd_nxt = sdram_cmd_pkg::CMD_NOP;
            endcase
          end
        end
      end
      sdram_cmd_pkg::MODE_SUSP: begin
        // New commands ignored; exit one edge after enable returns.
        if (!cke_prev_r && pins.cke) begin
          vld_nxt  = 1'b1;
          cmd_nxt  = sdram_cmd_pkg::CMD_SUSP_OUT;
          mode_nxt = sdram_cmd_pkg::MODE_RUN;
          run_nxt  = 1'b1;
        end
      end
      sdram_cmd_pkg::MODE_PD: begin
        if (!cke_prev_r && pins.cke) begin
          vld_nxt = 1'b1;
          if (nop_like) begin
            cmd_nxt  = sdram_cmd_pkg::CMD_PD_OUT;
            mode_nxt = sdram_cmd_pkg::MODE_RUN;
            run_nxt  = 1'b1;
          end else begin
            cmd_nxt = sdram_cmd_pkg::CMD_NOP;
            ill_nxt = 1'b1;
          end
        end
      end
      sdram_cmd_pkg::MODE_SREF: begin
        // Only enable is heard here; it returning high ends self refresh.
        if (pins.cke) begin
          vld_nxt  = 1'b1;
          cmd_nxt  = sdram_cmd_pkg::CMD_SREF_OUT;
          mode_nxt = sdram_cmd_pkg::MODE_RUN;
          run_nxt  = 1'b1;
        end
      end
    endcase
  end

  // ==========================================================================
  // Registers.
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      cke_prev_r  <= 1'b1;
      mode_r      <= sdram_cmd_pkg::MODE_RUN;
      run_r       <= 1'b1;
      act_r       <= '0;
      burst_r     <= 8'h00;
      full_page_r <= 1'b0;
      vld_r       <= 1'b0;
      cmd_r       <= sdram_cmd_pkg::CMD_NOP;
      bank_r      <= 2'h0;
      de_r        <= 1'b0;
      ill_r       <= 1'b0;
    end else begin
      cke_prev_r  <= cke_prev_nxt;
      mode_r      <= mode_nxt;
      run_r       <= run_nxt;
      act_r       <= act_nxt;
      burst_r     <= burst_nxt;
      full_page_r <= full_page_nxt;
      vld_r       <= vld_nxt;
      cmd_r       <= cmd_nxt;
      bank_r      <= bank_nxt;
      de_r        <= de_nxt;
      ill_r       <= ill_nxt;
    end
  end

  assign o_cmd_valid   = vld_r;
  assign o_cmd         = cmd_r;
  assign o_cmd_bank    = bank_r;
  assign o_bank_active = act_r;
  assign o_mode        = mode_r;
  assign o_clk_run     = run_r;
  assign o_burst_busy  = (burst_r != 8'h00);
  assign o_data_enable = de_r;
  assign o_illegal     = ill_r;

endmodule // sdram_cmd_decode
`default_nettype wire

/* File: verilog/sdram_cmd_if.sv */
// Command pins between the SDRAM controller and the device decoder.
`default_nettype none
interface sdram_cmd_if;
  logic        cs_n;            // Chip select, active low.
  logic        ras_n;           // Row strobe, active low.
  logic        cas_n;           // Column strobe, active low.
  logic        we_n;            // Write strobe, active low.
  logic        cke;             // Clock enable, active high.
  logic        dqm;             // Byte mask, high masks data.
  logic        bank_select_low; // Bank select bit 0.
  logic        bank_select_high;// Bank select bit 1.
  logic [11:0] addr;            // Address lines, precharge flag at bit 10.
  modport ctrl (output cs_n, ras_n, cas_n, we_n, cke, dqm,
                output bank_select_low, bank_select_high, addr);
  modport dev  (input cs_n, ras_n, cas_n, we_n, cke, dqm,
                input bank_select_low, bank_select_high, addr);
endinterface
`default_nettype wire

/* File: verilog/sdram_cmd_map.svh */
// Encodings and timing counts shared by both ends of the SDRAM command link.
`ifndef SDRAM_CMD_MAP_SVH
`define SDRAM_CMD_MAP_SVH

// ==========================================================================
// Command pin patterns {cs_n, ras_n, cas_n, we_n}.
`define PAT_NOP       4'h7
`define PAT_BSTOP     4'h6
`define PAT_READ      4'h5
`define PAT_WRITE     4'h4
`define PAT_ACT       4'h3
`define PAT_PRE       4'h2
`define PAT_REF       4'h1
`define PAT_MRS       4'h0
`define PAT_DESEL     4'h8
// ==========================================================================
// Widths and counts.
`define NUM_BANKS     4
`define ADDR_W        12
`define FLAG_BIT      10
`define BURST_LEN     8'h04
`define FULL_PAGE_LEN 8'hFF

`endif

/* File: verilog/sdram_cmd_pkg.sv */
// Types shared by the SDRAM command decoder and its controller.
`default_nettype none
package sdram_cmd_pkg;
  // Decoded command classes.
  typedef enum logic [3:0] {
    CMD_NOP, CMD_DESEL, CMD_ACT, CMD_PRE, CMD_PREALL, CMD_READ, CMD_WRITE,
    CMD_MRS, CMD_BSTOP, CMD_AREF, CMD_SREF_IN, CMD_SREF_OUT, CMD_SUSP_IN,
    CMD_SUSP_OUT, CMD_PD_IN, CMD_PD_OUT
  } cmd_t;
  // Device clock-enable modes, Gray coded along normal -> suspend -> back.
  typedef enum logic [1:0] {
    MODE_RUN  = 2'h0,
    MODE_SUSP = 2'h1,
    MODE_PD   = 2'h2,
    MODE_SREF = 2'h3
  } mode_t;
endpackage
`default_nettype wire
